// *** flash_ctl_pkg.sv ***
// Package with register map, field positions and constants of the flash code control block
package flash_ctl_pkg;
   // Register word byte addresses on the Avalon bus
   localparam logic [3:0] ADDR_CCS      = 4'h0;
   localparam logic [3:0] ADDR_KEY      = 4'h4;
   localparam logic [3:0] ADDR_SEL      = 4'h8;
   localparam logic [3:0] ADDR_DEST     = 4'hC;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h1;
   localparam int         ADDR_W        = 4;
   // Control status register field positions
   localparam int BIT_COPY  = 0;
   localparam int BIT_ERR   = 4;
   localparam int BIT_ONE7  = 7;
   // Reset value: bit 7 reads one, rest zero
   localparam logic [7:0] CCS_RESET     = 8'h80;
   localparam logic [7:0] KEY_DOWNLOAD  = 8'hA5;
   localparam logic [7:0] KEY_RESET     = 8'h00;
   // Select register field positions
   localparam int BIT_SEL_PROG  = 0;
   localparam int BIT_SEL_ERASE = 1;
   // Interrupt status/mask fields
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR  = 1;
   localparam int IRQ_W    = 2;
   // Offset of the interrupt mask register
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h2;
   // Download length in bytes per routine
   localparam int ROUTINE_LEN = 16;
   // Least reset hold after an error, in ms, and the clock
   localparam int ERR_RESET_MS = 100;
   localparam int CLK_MHZ      = 125;
   typedef enum logic [1:0] {ST_IDLE, ST_COPY, ST_DONE} copy_state_t;
endpackage

// *** copy_engine.sv ***
// Download engine that streams a built-in routine into on-chip RAM
`timescale 1ns/10ps
module copy_engine #(
   parameter int LEN = 16
) (
   input  wire logic        core_clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        start_i,
   input  wire logic        erase_i,
   input  wire logic [7:0]  dest_i,
   output logic             ram_we_o,
   output logic [7:0]       ram_addr_o,
   output logic [7:0]       ram_data_o,
   output logic             done_o
);
   import flash_ctl_pkg::*;

   copy_state_t state_r;
   logic [7:0]  idx_r;
   logic        erase_r;
   logic [7:0]  rom_word;
   wire         last_w = (idx_r == 8'(LEN - 1));

   // Built-in routine image, a simple pattern per routine kind
   assign rom_word = erase_r ? (idx_r ^ 8'h5_5) : (idx_r ^ 8'hA_A);

   // Step one byte per clock until the routine is copied
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r    <= ST_IDLE;
         idx_r      <= 8'h0_0;
         erase_r    <= 1'b0;
         ram_we_o   <= 1'b0;
         ram_addr_o <= 8'h0_0;
         ram_data_o <= 8'h0_0;
         done_o     <= 1'b0;
      end else begin
         ram_we_o <= 1'b0;
         done_o   <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (start_i) begin
                  state_r <= ST_COPY;
                  idx_r   <= 8'h0_0;
                  erase_r <= erase_i;
               end
            end
            ST_COPY: begin
               ram_we_o   <= 1'b1;
               ram_addr_o <= dest_i + idx_r;
               ram_data_o <= rom_word;
               idx_r      <= idx_r + 8'h0_1;
               if (last_w) begin
                  state_r <= ST_DONE;
               end
            end
            ST_DONE: begin
               done_o  <= 1'b1;
               state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end
endmodule

// *** flash_code_control.sv ***
// Flash code control status register block with download request and error protection
//
// What this block does
// - Bits 3 to 1 of the control status register read as zero.
// - Read-only error flag at bit 4 sets on a program or erase fault.
// - While the error flag is one, programming and erasing are blocked.
// - Only power-on reset or hardware standby clears the error flag; writes cannot.
// - Error flag zero means normal operation, protection off.
// - An accepted copy request downloads the selected routine to the destination.
// - Copy request bit clears when download ends; software never reads one.
// - Copy request sets only with key A5, RAM execution, emulation off.
// - Any key other than A5 blocks setting the copy request.
// - Program and erase select bits choose the routine and clear on completion.
// - Error flag survives software standby; request, key, selects and destination reinitialise.
//
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
module flash_code_control #(
   parameter int ROUTINE_BYTES = flash_ctl_pkg::ROUTINE_LEN
) (
   input  wire logic        core_clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        hw_standby_i,
   input  wire logic        soft_standby_i,
   input  wire logic        run_from_ram_i,
   input  wire logic        ram_emul_sel_i,
   input  wire logic        op_fault_i,
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   output logic             prog_erase_block_o,
   output logic             ram_we_o,
   output logic [7:0]       ram_addr_o,
   output logic [7:0]       ram_data_o,
   output logic             irq_o
);
   import flash_ctl_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Registers
   logic             err_r;
   logic             copy_r;
   logic [7:0]       key_r;
   logic             sel_prog_r;
   logic             sel_erase_r;
   logic [7:0]       dest_r;
   logic [IRQ_W-1:0] irq_stat_r;
   logic [IRQ_W-1:0] irq_mask_r;
   logic             ack_r;
   logic             copy_done;
   logic             eng_we;
   logic [7:0]       eng_addr;
   logic [7:0]       eng_data;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode; one wait cycle gives registered read data
   wire       access   = avs_read_i | avs_write_i;
   // Writes land at the edge that ends the wait, as the master sees it
   wire       wr_ok    = avs_write_i & ack_r & avs_byteenable_i[0];
   wire [7:0] wbyte    = avs_writedata_i[7:0];
   wire       sel_ccs  = (avs_address_i == ADDR_CCS);
   wire       sel_key  = (avs_address_i == ADDR_KEY);
   wire       sel_sel  = (avs_address_i == ADDR_SEL);
   wire       sel_dst  = (avs_address_i == ADDR_DEST) & ~avs_address_i[0];
   wire       sel_ist  = (avs_address_i == ADDR_IRQ_STAT);
   wire       sel_imk  = (avs_address_i == ADDR_IRQ_MASK);
   wire       wr_ccs   = wr_ok & sel_ccs;
   wire       busy     = copy_r;
   // Copy request acceptance gate
   wire       key_ok   = (key_r == KEY_DOWNLOAD);
   wire       copy_go  = wr_ccs & wbyte[BIT_COPY] & key_ok & run_from_ram_i
                         & ~ram_emul_sel_i & ~busy & (sel_prog_r | sel_erase_r);
   // Standby modes reinitialise request, key, selects and destination
   wire       reinit   = hw_standby_i | soft_standby_i;
   wire [7:0] ccs_view;
   wire [IRQ_W-1:0] irq_ev;
   wire [IRQ_W-1:0] irq_clr;
   wire [31:0] rd_mux;

   // Bit 7 reads one, reserved bits 6..5 and 3..1 read zero, copy reads zero
   assign ccs_view = {1'b1, 2'b00, err_r, 3'b000, 1'b0};
   assign irq_ev   = {op_fault_i & ~err_r, copy_done};
   assign irq_clr  = (wr_ok & sel_ist) ? wbyte[IRQ_W-1:0] : '0;
   assign rd_mux   = sel_ccs ? {24'h0000_00, ccs_view} :
                     sel_key ? {24'h0000_00, key_r} :
                     sel_sel ? {30'h0000_0000, sel_erase_r, sel_prog_r} :
                     sel_dst ? {24'h0000_00, dest_r} :
                     sel_ist ? {30'h0000_0000, irq_stat_r} :
                     sel_imk ? {30'h0000_0000, irq_mask_r} : 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake: waitrequest drops in the cycle after the request
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ack_r             <= 1'b0;
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0000_0000;
      end else begin
         // Own flop for waitrequest keeps the output free of an inverter
         ack_r             <= access & ~ack_r;
         avs_waitrequest_o <= ~(access & ~ack_r);
         avs_readdata_o    <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Error flag: only reset or hardware standby clears it, writes ignored
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         err_r <= 1'b0;
      end else if (op_fault_i) begin
         err_r <= 1'b1;
      end else if (hw_standby_i) begin
         err_r <= 1'b0;
      end
   end

   // Protection output follows the flag; clear means normal operation
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prog_erase_block_o <= 1'b0;
      end else begin
         prog_erase_block_o <= err_r | op_fault_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Request, key, selects and destination
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         copy_r      <= 1'b0;
         key_r       <= KEY_RESET;
         sel_prog_r  <= 1'b0;
         sel_erase_r <= 1'b0;
         dest_r      <= 8'h0_0;
      end else if (reinit) begin
         copy_r      <= 1'b0;
         key_r       <= KEY_RESET;
         sel_prog_r  <= 1'b0;
         sel_erase_r <= 1'b0;
         dest_r      <= 8'h0_0;
      end else begin
         if (copy_go) begin
            copy_r <= 1'b1;
         end else if (copy_done) begin
            copy_r <= 1'b0;
         end
         if (wr_ok & sel_key) begin
            key_r <= wbyte;
         end
         if (copy_done) begin
            sel_prog_r  <= 1'b0;
            sel_erase_r <= 1'b0;
         end else if (wr_ok & sel_sel & ~busy) begin
            sel_prog_r  <= wbyte[BIT_SEL_PROG];
            sel_erase_r <= wbyte[BIT_SEL_ERASE];
         end
         if (wr_ok & sel_dst & ~busy) begin
            dest_r <= wbyte;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status: set beats the write-one clear
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_stat_r <= '0;
         irq_mask_r <= '0;
         irq_o      <= 1'b0;
      end else begin
         irq_stat_r <= irq_ev | (irq_stat_r & ~irq_clr);
         if (wr_ok & sel_imk) begin
            irq_mask_r <= wbyte[IRQ_W-1:0];
         end
         irq_o <= |(irq_stat_r & irq_mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Download engine; erase routine chosen when its select is set
   copy_engine #(.LEN(ROUTINE_BYTES)) copy_engine_inst (
      .core_clk_i (core_clk_i),
      .arst_n_i   (arst_n_i),
      .start_i    (copy_go),
      .erase_i    (sel_erase_r),
      .dest_i     (dest_r),
      .ram_we_o   (eng_we),
      .ram_addr_o (eng_addr),
      .ram_data_o (eng_data),
      .done_o     (copy_done)
   );
   assign ram_we_o   = eng_we;
   assign ram_addr_o = eng_addr;
   assign ram_data_o = eng_data;

   ////////////////////////////////////////////////////////////////////////
   // Checks: error flag and protection
   a_err_sticky: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      err_r && !hw_standby_i |=> err_r)
      else $error("error flag dropped without standby");

   a_err_sets: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      op_fault_i |=> err_r)
      else $error("fault did not set error flag");

   a_err_no_write: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      !err_r && !op_fault_i |=> !err_r)
      else $error("error flag set without a fault");

   a_err_hw_clear: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      hw_standby_i && !op_fault_i |=> !err_r)
      else $error("hardware standby left error flag set");

   a_err_event: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      op_fault_i && !err_r |=> irq_stat_r[IRQ_ERR])
      else $error("first fault raised no error event");

   a_protect_follow: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      err_r |=> prog_erase_block_o)
      else $error("protection off while error set");

   a_protect_off: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      $past(!err_r && !op_fault_i) |-> !prog_erase_block_o)
      else $error("protection on without error");

   // Checks: download request
   a_key_gate: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      copy_go |-> key_r == KEY_DOWNLOAD && run_from_ram_i && !ram_emul_sel_i)
      else $error("copy accepted without conditions");

   a_bad_key: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      !copy_r && key_r != KEY_DOWNLOAD && !reinit |=> !copy_r)
      else $error("copy set with wrong key");

   a_copy_clears: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      copy_done && !reinit |=> !copy_r && !sel_prog_r && !sel_erase_r)
      else $error("request or select not cleared");

   a_copy_runs: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      copy_go |-> ##[1:300] copy_done)
      else $error("download never completed");

   a_ram_dest: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      ram_we_o && !$past(ram_we_o) && !$past(reinit) |-> ram_addr_o == dest_r)
      else $error("download did not start at destination");

   a_sel_hold: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      copy_r && !copy_done && !reinit |=> $stable(sel_prog_r) && $stable(sel_erase_r))
      else $error("select changed during download");

   a_dest_hold: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      copy_r && !reinit |=> $stable(dest_r))
      else $error("destination changed during download");

   a_standby_keeps: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      soft_standby_i && !hw_standby_i && err_r |=> err_r && key_r == KEY_RESET)
      else $error("soft standby handling wrong");

   // Checks: bus handshake and interrupt
   a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      avs_read_i && !avs_waitrequest_o && avs_address_i == ADDR_CCS
      |-> avs_readdata_o[3:1] == 3'b000)
      else $error("reserved bits not zero");

   a_copy_hidden: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      avs_read_i && !avs_waitrequest_o && avs_address_i == ADDR_CCS
      |-> !avs_readdata_o[BIT_COPY])
      else $error("copy request bit read as one");

   a_wait_pulse: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      !avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");

   a_wait_idle: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      !avs_read_i && !avs_write_i |=> avs_waitrequest_o)
      else $error("waitrequest low without a request");

   a_wait_answer: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("request not answered after one wait cycle");

   a_irq_high: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      |(irq_stat_r & irq_mask_r) |=> irq_o)
      else $error("interrupt low with unmasked status");

   a_irq_low: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      !(|(irq_stat_r & irq_mask_r)) |=> !irq_o)
      else $error("interrupt high without unmasked status");

   a_done_stat: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      copy_done |=> irq_stat_r[IRQ_DONE])
      else $error("download end raised no status");

   a_stat_keep: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      irq_stat_r[IRQ_DONE] && !irq_clr[IRQ_DONE] |=> irq_stat_r[IRQ_DONE])
      else $error("status bit dropped without clear");
endmodule

// *** flash_code_control_bench.sv ***
// Self-checking bench for the flash code control status block
`timescale 1ns/10ps
module flash_code_control_bench;
   import flash_ctl_pkg::*;
   localparam int NBYTES = 8;
   logic core_clk_i, arst_n_i, hw_standby_i, soft_standby_i, run_from_ram_i, ram_emul_sel_i;
   logic        op_fault_i, avs_read_i, avs_write_i;
   logic [3:0]  avs_address_i, avs_byteenable_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, rd;
   logic        avs_waitrequest_o, prog_erase_block_o, ram_we_o, irq_o;
   logic [7:0]  ram_addr_o, ram_data_o, first_addr, first_data;
   int          n_mismatch, checks_done, n_we, cyc;

   flash_code_control #(.ROUTINE_BYTES(NBYTES)) flash_code_control_inst (
      .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .hw_standby_i(hw_standby_i),
      .soft_standby_i(soft_standby_i), .run_from_ram_i(run_from_ram_i),
      .ram_emul_sel_i(ram_emul_sel_i), .op_fault_i(op_fault_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .prog_erase_block_o(prog_erase_block_o), .ram_we_o(ram_we_o), .ram_addr_o(ram_addr_o),
      .ram_data_o(ram_data_o), .irq_o(irq_o));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard; ceiling well above the few hundred cycles needed
   initial begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end
   // Download byte counter, first address kept for the destination check
   always @(posedge core_clk_i) begin
      if (ram_we_o === 1'b1) begin
         if (n_we == 0) begin
            first_addr = ram_addr_o;
            first_data = ram_data_o;
         end
         n_we++;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Comparison and closing
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Bus cycles: request held until waitrequest seen low, then one idle edge
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= 1'b1;
      @(posedge core_clk_i);
      while (avs_waitrequest_o !== 1'b0) @(posedge core_clk_i);
      avs_write_i <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
      avs_address_i <= a;
      avs_read_i <= 1'b1;
      @(posedge core_clk_i);
      while (avs_waitrequest_o !== 1'b0) @(posedge core_clk_i);
      d = avs_readdata_o;
      avs_read_i <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] v;
      bus_rd(a, v);
      check(v, exp);
   endtask
   // One download attempt with given key, execution place, emulation and select
   task automatic try_copy(input logic [7:0] key, input logic ram, input logic emul,
                           input logic [1:0] sel, input int exp_bytes);
      run_from_ram_i <= ram;
      ram_emul_sel_i <= emul;
      bus_wr(ADDR_KEY, {24'h00_0000, key});
      bus_wr(ADDR_SEL, {30'h0000_0000, sel});
      bus_wr(ADDR_DEST, 32'h0000_0040);
      n_we = 0;
      bus_wr(ADDR_CCS, 32'h0000_0081);
      repeat (NBYTES + 8) @(posedge core_clk_i);
      check(32'(n_we), 32'(exp_bytes));
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {arst_n_i, hw_standby_i, soft_standby_i, run_from_ram_i, ram_emul_sel_i} = 5'h00;
      {op_fault_i, avs_read_i, avs_write_i} = 3'h0;
      avs_address_i = 4'h0;
      avs_writedata_i = 32'h0000_0000;
      avs_byteenable_i = 4'h1;
      n_mismatch = 0;
      checks_done = 0;
      n_we = 0;
      cyc = 0;
      repeat (2) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      @(posedge core_clk_i);
      rd_chk(ADDR_CCS, 32'h0000_0080);
      check(32'(prog_erase_block_o), 32'h0000_0000);
      rd_chk(4'h3, 32'h0000_0000);
      // Software cannot set the flag, copy bit never reads one
      // Flag and copy bits written high, reserved bits kept at zero
      bus_wr(ADDR_CCS, 32'h0000_0091);
      rd_chk(ADDR_CCS, 32'h0000_0080);
      // Refused requests: wrong key, emulation on, not in RAM, no select
      try_copy(8'h5A, 1'b1, 1'b0, 2'h1, 0);
      try_copy(8'hA5, 1'b1, 1'b1, 2'h1, 0);
      try_copy(8'hA5, 1'b0, 1'b0, 2'h1, 0);
      try_copy(8'hA5, 1'b1, 1'b0, 2'h0, 0);
      // Accepted program download, selects clear on completion
      try_copy(8'hA5, 1'b1, 1'b0, 2'h1, NBYTES);
      check(32'(first_addr), 32'h0000_0040);
      check(32'(first_data), 32'h0000_00AA);
      rd_chk(ADDR_SEL, 32'h0000_0000);
      rd_chk(ADDR_CCS, 32'h0000_0080);
      // Done event raised while masked, then unmasked, then cleared
      rd_chk(4'h1, 32'h0000_0001);
      check(32'(irq_o), 32'h0000_0000);
      bus_wr(4'h2, 32'h0000_0001);
      @(posedge core_clk_i);
      check(32'(irq_o), 32'h0000_0001);
      bus_wr(4'h1, 32'h0000_0001);
      rd_chk(4'h1, 32'h0000_0000);
      check(32'(irq_o), 32'h0000_0000);
      // Erase download
      try_copy(8'hA5, 1'b1, 1'b0, 2'h2, NBYTES);
      rd_chk(ADDR_SEL, 32'h0000_0000);
      bus_wr(4'h1, 32'h0000_0003);
      // Fault pulse sets the sticky flag and protection
      op_fault_i <= 1'b1;
      @(posedge core_clk_i);
      op_fault_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      check(32'(prog_erase_block_o), 32'h0000_0001);
      rd_chk(ADDR_CCS, 32'h0000_0090);
      bus_wr(ADDR_CCS, 32'h0000_0080);
      rd_chk(ADDR_CCS, 32'h0000_0090);
      bus_wr(4'h2, 32'h0000_0002);
      @(posedge core_clk_i);
      check(32'(irq_o), 32'h0000_0001);
      // Software standby keeps the flag, clears the key
      soft_standby_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      soft_standby_i <= 1'b0;
      @(posedge core_clk_i);
      rd_chk(ADDR_CCS, 32'h0000_0090);
      rd_chk(ADDR_KEY, 32'h0000_0000);
      // Hardware standby clears the flag and protection
      hw_standby_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      hw_standby_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      rd_chk(ADDR_CCS, 32'h0000_0080);
      check(32'(prog_erase_block_o), 32'h0000_0000);
      // Mid-run reset only while the flag is clear, so no long hold is owed
      bus_wr(ADDR_KEY, 32'h0000_00A5);
      arst_n_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      @(posedge core_clk_i);
      check(32'(avs_waitrequest_o), 32'h0000_0001);
      rd_chk(ADDR_KEY, 32'h0000_0000);
      rd_chk(ADDR_CCS, 32'h0000_0080);
      stop_test();
   end
endmodule
